// ### src/dac_path_pkg.sv
// Shared constants and types for the dual converter input latch path
package dac_path_pkg;

   // ***********************************************************
   // Widths and reset values
   // ***********************************************************
   localparam int         DATA_W     = 12;
   localparam logic [11:0] CODE_RESET = 12'h000;

   // ***********************************************************
   // Timing, clock period 5 ns
   // ***********************************************************
   localparam int CLK_PERIOD_PS = 5000;
   // Recovery from sleep, rounded up to whole cycles
   localparam int WAKE_US       = 5;
   localparam int WAKE_CYCLES   = (WAKE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WAKE_CNT_W    = 10;
   localparam logic [9:0] WAKE_LAST = 10'(WAKE_CYCLES - 1);
   localparam logic [9:0] WAKE_ZERO = 10'h000;
   // Source holds the divider phase reset this long after reset or a change to interleaved mode
   localparam logic [2:0] PHASE_RESET_HOLD = 3'h4;
   localparam logic [2:0] HOLD_ZERO        = 3'h0;

   // ***********************************************************
   // State types
   // ***********************************************************
   typedef enum logic [1:0] {PWR_ON, PWR_SLEEP, PWR_WAKE} pwr_e;

   typedef enum logic [2:0] {
      SRC_PHASE_RESET,
      SRC_IDLE,
      SRC_SETUP_A,
      SRC_EDGE_A,
      SRC_GAP,
      SRC_SETUP_B,
      SRC_EDGE_B
   } src_e;

endpackage : dac_path_pkg

// ### src/dac_link_if.sv
// Pin bundle between the data source and the dual converter input path
interface dac_link_if;
   logic        modeDual;
   logic        ch1WriteStrobe;
   logic        ch2WriteStrobe;
   logic        ch1UpdateClock;
   logic        ch2UpdateClock;
   logic [11:0] ch1Data;
   logic [11:0] ch2Data;
   logic        powerDown;

   modport device (
      input modeDual,
      input ch1WriteStrobe,
      input ch2WriteStrobe,
      input ch1UpdateClock,
      input ch2UpdateClock,
      input ch1Data,
      input ch2Data,
      input powerDown
   );

   modport source (
      output modeDual,
      output ch1WriteStrobe,
      output ch2WriteStrobe,
      output ch1UpdateClock,
      output ch2UpdateClock,
      output ch1Data,
      output ch2Data,
      output powerDown
   );
endinterface : dac_link_if

// ### src/pin_sync.sv
// Two-flop pin synchroniser with a rising-edge pulse on bit 0
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level,
   output logic                  rise
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_level;
   logic             lastBit;
   logic             next_lastBit;
   logic             next_rise;

   // Only the second stage is looked at; the first may be metastable
   always_comb
   begin
      next_meta    = pin;
      next_level   = meta;
      next_lastBit = level[0];
      next_rise    = level[0] & ~lastBit;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta    <= '0;
         level   <= '0;
         lastBit <= 1'b0;
         rise    <= 1'b0;
      end
      else
      begin
         meta    <= next_meta;
         level   <= next_level;
         lastBit <= next_lastBit;
         rise    <= next_rise;
      end
   end

endmodule : pin_sync

// ### src/dac_input_path.sv
// Device end: double-buffered input latches, mode steering and sleep control
//
// Contract
// - Input latch first, converter latch drives output
// - Latches load on strobe and clock rising edges
// - Update clock no later than strobe, else 2ns
// - Mode low selects interleaved pin functions
// - Interleaved: capture shared port on strobe rise
// - Steer select 1 to latch one, 0 two
// - Steer select changes only while both low
// - Phase reset high blocks all converter updates
// - First edge after phase reset loads both
// - Interleaved update clock divided by two
// - Shared clock edge not after shared strobe
// - Power-down high: outputs off, 5us recovery
// - Undriven power-down means converting
// - Source changes data near falling edge
// - Mode high: two independent channels
// - Twelve-bit straight binary, msb highest bit
// - Dual mode: update on every own clock
module dac_input_path (
   input  wire logic        clk,
   input  wire logic        rstn,
   dac_link_if.device       link,
   output logic [11:0]      dac1Code,
   output logic [11:0]      dac2Code,
   output logic             outputOn,
   output logic             sleeping
);

   // ***********************************************************
   // Pin synchronisers
   // ***********************************************************
   logic [3:0]  ctlPin;
   logic [3:0]  ctlLevel;
   logic [3:0]  ctlRise;
   logic [11:0] data1;
   logic [11:0] data2;
   logic        modeDual;
   logic        pdLevel;

   // Strobes and clocks share one synchroniser shape with data; their rise pulse comes one cycle after the data level
   assign ctlPin = {link.ch2UpdateClock, link.ch1UpdateClock,
                    link.ch2WriteStrobe, link.ch1WriteStrobe};

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_ctl
         pin_sync #(.WIDTH(1)) u_sync (
            .clk   (clk),
            .rstn  (rstn),
            .pin   (ctlPin[g]),
            .level (ctlLevel[g]),
            .rise  (ctlRise[g])
         );
      end
   endgenerate

   // Data words, straight binary with bit 11 as msb
   pin_sync #(.WIDTH(dac_path_pkg::DATA_W)) u_data1 (
      .clk   (clk),
      .rstn  (rstn),
      .pin   (link.ch1Data),
      .level (data1),
      .rise  ()
   );

   pin_sync #(.WIDTH(dac_path_pkg::DATA_W)) u_data2 (
      .clk   (clk),
      .rstn  (rstn),
      .pin   (link.ch2Data),
      .level (data2),
      .rise  ()
   );

   pin_sync #(.WIDTH(1)) u_mode (
      .clk   (clk),
      .rstn  (rstn),
      .pin   (link.modeDual),
      .level (modeDual),
      .rise  ()
   );

   pin_sync #(.WIDTH(1)) u_pd (
      .clk   (clk),
      .rstn  (rstn),
      .pin   (link.powerDown),
      .level (pdLevel),
      .rise  ()
   );

   // ***********************************************************
   // Pin role decode
   // ***********************************************************
   logic write1;
   logic write2;
   logic steer;
   logic phaseReset;
   logic sharedWrite;
   logic sharedClock;
   logic update1Dual;
   logic update2Dual;

   // In interleaved mode the channel two pins change meaning
   assign sharedWrite = ~modeDual & ctlRise[0];
   assign steer       = ctlLevel[1];
   assign sharedClock = ~modeDual & ctlRise[2];
   assign phaseReset  = ~modeDual & ctlLevel[3];
   // Steer is sampled with the strobe edge; the source keeps it still meanwhile
   assign write1 = modeDual ? ctlRise[0] : (sharedWrite & steer);
   assign write2 = modeDual ? ctlRise[1] : (sharedWrite & ~steer);
   assign update1Dual = modeDual & ctlRise[2];
   assign update2Dual = modeDual & ctlRise[3];

   // ***********************************************************
   // Channel and converter latches
   // ***********************************************************
   logic [11:0] chLatch1;
   logic [11:0] chLatch2;
   logic [11:0] next_chLatch1;
   logic [11:0] next_chLatch2;
   logic [11:0] next_dac1Code;
   logic [11:0] next_dac2Code;
   logic        divPhase;
   logic        next_divPhase;
   logic        iqUpdate;

   // A shared clock edge loads both only on the even phase of the divider
   assign iqUpdate = sharedClock & ~phaseReset & ~divPhase;

   // Converter loads use the old channel latch, so a clock edge coincident
   // with a strobe edge takes the previous word, as the source expects
   always_comb
   begin
      next_chLatch1 = chLatch1;
      next_chLatch2 = chLatch2;
      next_dac1Code = dac1Code;
      next_dac2Code = dac2Code;
      next_divPhase = divPhase;
      if (write1)
      begin
         next_chLatch1 = modeDual ? data1 : data1;
      end
      if (write2)
      begin
         next_chLatch2 = modeDual ? data2 : data1;
      end
      if (update1Dual || iqUpdate)
      begin
         next_dac1Code = chLatch1;
      end
      if (update2Dual || iqUpdate)
      begin
         next_dac2Code = chLatch2;
      end
      if (phaseReset || modeDual)
      begin
         next_divPhase = 1'b0;
      end
      else if (sharedClock)
      begin
         next_divPhase = ~divPhase;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         chLatch1 <= dac_path_pkg::CODE_RESET;
         chLatch2 <= dac_path_pkg::CODE_RESET;
         dac1Code <= dac_path_pkg::CODE_RESET;
         dac2Code <= dac_path_pkg::CODE_RESET;
         divPhase <= 1'b0;
      end
      else
      begin
         chLatch1 <= next_chLatch1;
         chLatch2 <= next_chLatch2;
         dac1Code <= next_dac1Code;
         dac2Code <= next_dac2Code;
         divPhase <= next_divPhase;
      end
   end

   // ***********************************************************
   // Sleep control
   // ***********************************************************
   dac_path_pkg::pwr_e pwrState;
   dac_path_pkg::pwr_e next_pwrState;
   logic [9:0]         wakeCnt;
   logic [9:0]         next_wakeCnt;
   logic               next_outputOn;
   logic               next_sleeping;

   // Entry takes three cycles after the pin, well under 50 ns; a low pin
   // (including an undriven one pulled low outside) keeps the outputs on
   always_comb
   begin
      next_pwrState = pwrState;
      next_wakeCnt  = wakeCnt;
      unique case (pwrState)
         dac_path_pkg::PWR_ON:
         begin
            if (pdLevel)
            begin
               next_pwrState = dac_path_pkg::PWR_SLEEP;
            end
         end
         dac_path_pkg::PWR_SLEEP:
         begin
            if (!pdLevel)
            begin
               next_pwrState = dac_path_pkg::PWR_WAKE;
               next_wakeCnt  = dac_path_pkg::WAKE_ZERO;
            end
         end
         dac_path_pkg::PWR_WAKE:
         begin
            if (pdLevel)
            begin
               next_pwrState = dac_path_pkg::PWR_SLEEP;
            end
            else if (wakeCnt == dac_path_pkg::WAKE_LAST)
            begin
               next_pwrState = dac_path_pkg::PWR_ON;
            end
            else
            begin
               next_wakeCnt = wakeCnt + 10'h001;
            end
         end
      endcase
      next_outputOn = (next_pwrState == dac_path_pkg::PWR_ON);
      next_sleeping = (next_pwrState == dac_path_pkg::PWR_SLEEP);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pwrState <= dac_path_pkg::PWR_ON;
         wakeCnt  <= dac_path_pkg::WAKE_ZERO;
         outputOn <= 1'b1;
         sleeping <= 1'b0;
      end
      else
      begin
         pwrState <= next_pwrState;
         wakeCnt  <= next_wakeCnt;
         outputOn <= next_outputOn;
         sleeping <= next_sleeping;
      end
   end

endmodule : dac_input_path

// ### src/dac_data_source.sv
// Source end: drives sample words, strobes and update clocks onto the link
module dac_data_source (
   input  wire logic        clk,
   input  wire logic        rstn,
   dac_link_if.source       link,
   input  wire logic [11:0] userData1,
   input  wire logic [11:0] userData2,
   input  wire logic        userValid,
   input  wire logic        userModeDual,
   input  wire logic        userPowerDown,
   output logic             userReady
);

   // ***********************************************************
   // Sequencer
   // ***********************************************************
   dac_path_pkg::src_e state;
   dac_path_pkg::src_e next_state;
   logic [2:0]  holdCnt;
   logic [2:0]  next_holdCnt;
   logic        mode;
   logic        next_mode;
   logic [11:0] word2;
   logic [11:0] next_word2;
   logic [11:0] d1;
   logic [11:0] next_d1;
   logic [11:0] d2;
   logic [11:0] next_d2;
   logic        ch1_write_strobe;
   logic        next_ch1_write_strobe;
   logic        ch2_write_strobe;
   logic        next_ch2_write_strobe;
   logic        ch1_update_clock;
   logic        next_ch1_update_clock;
   logic        ch2_update_clock;
   logic        next_ch2_update_clock;
   logic        pd;
   logic        next_pd;
   logic        next_userReady;

   // Data and select move only while strobes are low, one cycle before the rise;
   // clock and strobe rise together so the converter takes the previous word
   always_comb
   begin
      next_state   = state;
      next_holdCnt = holdCnt;
      next_mode    = mode;
      next_word2   = word2;
      next_d1      = d1;
      next_d2      = d2;
      next_ch1_write_strobe    = 1'b0;
      next_ch2_write_strobe    = mode ? 1'b0 : ch2_write_strobe;
      next_ch1_update_clock    = 1'b0;
      next_ch2_update_clock    = 1'b0;
      next_pd      = userPowerDown;
      unique case (state)
         dac_path_pkg::SRC_PHASE_RESET:
         begin
            next_ch2_update_clock = ~mode;
            if (holdCnt == dac_path_pkg::HOLD_ZERO)
            begin
               next_state = dac_path_pkg::SRC_IDLE;
               next_ch2_update_clock  = 1'b0;
            end
            else
            begin
               next_holdCnt = holdCnt - 3'h1;
            end
         end
         dac_path_pkg::SRC_IDLE:
         begin
            if (userModeDual != mode)
            begin
               next_mode    = userModeDual;
               next_holdCnt = dac_path_pkg::PHASE_RESET_HOLD;
               next_state   = dac_path_pkg::SRC_PHASE_RESET;
            end
            else if (userValid)
            begin
               next_d1    = userData1;
               next_d2    = userData2;
               next_word2 = userData2;
               next_ch2_write_strobe  = ~mode;
               next_state = dac_path_pkg::SRC_SETUP_A;
            end
         end
         dac_path_pkg::SRC_SETUP_A:
         begin
            next_ch1_write_strobe  = 1'b1;
            next_ch1_update_clock  = 1'b1;
            next_ch2_write_strobe  = mode ? 1'b1 : ch2_write_strobe;
            next_ch2_update_clock  = mode;
            next_state = dac_path_pkg::SRC_EDGE_A;
         end
         dac_path_pkg::SRC_EDGE_A:
         begin
            next_state = mode ? dac_path_pkg::SRC_IDLE : dac_path_pkg::SRC_GAP;
         end
         dac_path_pkg::SRC_GAP:
         begin
            next_d1    = word2;
            next_ch2_write_strobe  = 1'b0;
            next_state = dac_path_pkg::SRC_SETUP_B;
         end
         dac_path_pkg::SRC_SETUP_B:
         begin
            next_ch1_write_strobe  = 1'b1;
            next_ch1_update_clock  = 1'b1;
            next_state = dac_path_pkg::SRC_EDGE_B;
         end
         dac_path_pkg::SRC_EDGE_B:
         begin
            next_state = dac_path_pkg::SRC_IDLE;
         end
         default:
         begin
            next_state = dac_path_pkg::SRC_IDLE;
         end
      endcase
      next_userReady = (next_state == dac_path_pkg::SRC_IDLE)
                       && (userModeDual == next_mode);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state     <= dac_path_pkg::SRC_PHASE_RESET;
         holdCnt   <= dac_path_pkg::PHASE_RESET_HOLD;
         mode      <= 1'b0;
         word2     <= dac_path_pkg::CODE_RESET;
         d1        <= dac_path_pkg::CODE_RESET;
         d2        <= dac_path_pkg::CODE_RESET;
         ch1_write_strobe      <= 1'b0;
         ch2_write_strobe      <= 1'b0;
         ch1_update_clock      <= 1'b0;
         ch2_update_clock      <= 1'b0;
         pd        <= 1'b0;
         userReady <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         holdCnt   <= next_holdCnt;
         mode      <= next_mode;
         word2     <= next_word2;
         d1        <= next_d1;
         d2        <= next_d2;
         ch1_write_strobe      <= next_ch1_write_strobe;
         ch2_write_strobe      <= next_ch2_write_strobe;
         ch1_update_clock      <= next_ch1_update_clock;
         ch2_update_clock      <= next_ch2_update_clock;
         pd        <= next_pd;
         userReady <= next_userReady;
      end
   end

   // Every link pin comes straight from a flop
   assign link.modeDual       = mode;
   assign link.ch1WriteStrobe = ch1_write_strobe;
   assign link.ch2WriteStrobe = ch2_write_strobe;
   assign link.ch1UpdateClock = ch1_update_clock;
   assign link.ch2UpdateClock = ch2_update_clock;
   assign link.ch1Data        = d1;
   assign link.ch2Data        = d2;
   assign link.powerDown      = pd;

endmodule : dac_data_source

// ### dv/dac_link_monitor.sv
// Concurrent checks on the link between the source end and the converter end
module dac_link_monitor (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        modeDual,
   input wire logic        ch1WriteStrobe,
   input wire logic        ch2WriteStrobe,
   input wire logic        ch1UpdateClock,
   input wire logic        ch2UpdateClock,
   input wire logic [11:0] ch1Data,
   input wire logic [11:0] ch2Data,
   input wire logic        powerDown,
   input wire logic [11:0] dac1Code,
   input wire logic [11:0] dac2Code,
   input wire logic        outputOn,
   input wire logic        sleeping
);
   timeunit 1ns;
   timeprecision 1ps;

   // *****************************************
   // Helper counters
   // *****************************************
   logic [3:0] sinceClk1;
   logic [3:0] sinceClk2;
   logic [3:0] next_sinceClk1;
   logic [3:0] next_sinceClk2;
   logic       clk2Eff;

   // Ages saturate so a long idle never wraps into a false cause
   always_comb
   begin
      clk2Eff = modeDual ? ch2UpdateClock : ch1UpdateClock;
      next_sinceClk1 = (sinceClk1 == 4'hF) ? sinceClk1 : sinceClk1 + 4'h1;
      next_sinceClk2 = (sinceClk2 == 4'hF) ? sinceClk2 : sinceClk2 + 4'h1;
      if (ch1UpdateClock)
         next_sinceClk1 = 4'h0;
      if (clk2Eff)
         next_sinceClk2 = 4'h0;
   end

   // Registers only
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sinceClk1 <= 4'hF;
         sinceClk2 <= 4'hF;
      end
      else
      begin
         sinceClk1 <= next_sinceClk1;
         sinceClk2 <= next_sinceClk2;
      end
   end

   // *****************************************
   // Assertions
   // *****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   sequence strobeRise;
      $rose(ch1WriteStrobe);
   endsequence

   // Four cycles of held phase reset cover the converter's synchroniser and
   // edge-detect latency, so no earlier clock edge can still be in flight
   sequence phaseHeld;
      (!modeDual && ch2UpdateClock) [*4];
   endsequence

   a_data_settled: assert property (strobeRise |-> $stable(ch1Data) && $stable(ch2Data))
      else $error("data moved at the strobe edge");
   a_clock_not_late: assert property (strobeRise |-> ch1UpdateClock)
      else $error("update clock later than write strobe");
   a_clock2_not_late: assert property (modeDual && $rose(ch2WriteStrobe) |-> ch2UpdateClock)
      else $error("second update clock later than its strobe");
   a_steer_when_low: assert property (!modeDual && $stable(modeDual) && $changed(ch2WriteStrobe)
      |-> !ch1WriteStrobe && !ch1UpdateClock && !$past(ch1WriteStrobe))
      else $error("steer select moved while strobe or clock high");
   a_phase_blocks: assert property (phaseHeld |-> $stable(dac1Code) && $stable(dac2Code))
      else $error("converter updated during phase reset");
   a_code1_cause: assert property ($changed(dac1Code) |-> sinceClk1 <= 4'h6)
      else $error("first converter code moved without an update clock");
   a_code2_cause: assert property ($changed(dac2Code) |-> sinceClk2 <= 4'h6)
      else $error("second converter code moved without an update clock");
   a_sleep_entry: assert property ($rose(powerDown) |-> ##[1:9] (sleeping && !outputOn))
      else $error("sleep entry too slow");
   a_wake_delay: assert property ($fell(sleeping) |-> !outputOn [*8])
      else $error("output back on without recovery time");
endmodule : dac_link_monitor

// ### dv/tb_dual_dac_input_latch_path.sv
// Self-checking bench: source and converter ends face each other, plus a bench-driven converter
module tb_dual_dac_input_latch_path;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        rstn;
   logic [11:0] userData1;
   logic [11:0] userData2;
   logic        userValid;
   logic        userModeDual;
   logic        userPowerDown;
   logic        userReady;
   logic [11:0] dac1A;
   logic [11:0] dac2A;
   logic        onA;
   logic        sleepA;
   logic [11:0] dac1B;
   logic [11:0] dac2B;
   logic        onB;
   logic        sleepB;
   logic        steerB;
   logic        phaseB;
   int          miscompares;
   int          nTests;

   dac_link_if linkA ();
   dac_link_if linkB ();

   dac_data_source i_dac_data_source (.clk(clk), .rstn(rstn), .link(linkA),
      .userData1(userData1), .userData2(userData2), .userValid(userValid),
      .userModeDual(userModeDual), .userPowerDown(userPowerDown), .userReady(userReady));
   dac_input_path i_dac_input_path (.clk(clk), .rstn(rstn), .link(linkA),
      .dac1Code(dac1A), .dac2Code(dac2A), .outputOn(onA), .sleeping(sleepA));
   // Second converter end, driven pin by pin so refused cases can be provoked
   dac_input_path i_dac_input_path_b (.clk(clk), .rstn(rstn), .link(linkB),
      .dac1Code(dac1B), .dac2Code(dac2B), .outputOn(onB), .sleeping(sleepB));
   dac_link_monitor i_dac_link_monitor (.clk(clk), .rstn(rstn), .modeDual(linkA.modeDual),
      .ch1WriteStrobe(linkA.ch1WriteStrobe), .ch2WriteStrobe(linkA.ch2WriteStrobe),
      .ch1UpdateClock(linkA.ch1UpdateClock), .ch2UpdateClock(linkA.ch2UpdateClock),
      .ch1Data(linkA.ch1Data), .ch2Data(linkA.ch2Data), .powerDown(linkA.powerDown),
      .dac1Code(dac1A), .dac2Code(dac2A), .outputOn(onA), .sleeping(sleepA));

   // 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // *****************************************
   // Tasks
   // *****************************************
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      nTests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   // Inputs move 1 ns after the rising edge, away from sampling
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   // Pattern is {ch1_write_strobe, ch2_write_strobe, ch1_update_clock, ch2_update_clock}; steer and phase reset levels are kept
   task automatic pulse_b(input logic [3:0] pat);
      {linkB.ch1WriteStrobe, linkB.ch2WriteStrobe, linkB.ch1UpdateClock, linkB.ch2UpdateClock}
         = pat | {1'b0, steerB, 1'b0, phaseB};
      cyc(2);
      {linkB.ch1WriteStrobe, linkB.ch2WriteStrobe, linkB.ch1UpdateClock, linkB.ch2UpdateClock}
         = {1'b0, steerB, 1'b0, phaseB};
      cyc(6);
   endtask : pulse_b

   // Interleaved word: steer settles while strobe and clock are low
   task automatic load_b(input logic [11:0] d, input logic s);
      steerB = s;
      linkB.ch2WriteStrobe = s;
      linkB.ch1Data = d;
      cyc(2);
      pulse_b(4'h8);
   endtask : load_b

   // Bounded wait for the source to accept, then one request
   task automatic send(input logic [11:0] d1, input logic [11:0] d2);
      for (int i = 0; i < 60 && userReady !== 1'b1; i++)
         cyc(1);
      if (userReady !== 1'b1)
      begin
         miscompares++;
         wrap_up();
      end
      userData1 = d1;
      userData2 = d2;
      userValid = 1'b1;
      cyc(1);
      userValid = 1'b0;
      cyc(10);
   endtask : send

   // Watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      wrap_up();
   end

   // *****************************************
   // Main sequence
   // *****************************************
   initial
   begin
      miscompares = 0;
      nTests = 0;
      rstn = 1'b0;
      {userData1, userData2, userValid, userModeDual, userPowerDown} = '0;
      {steerB, phaseB} = 2'b00;
      {linkB.ch1WriteStrobe, linkB.ch2WriteStrobe, linkB.ch1UpdateClock} = 3'b000;
      {linkB.ch2UpdateClock, linkB.powerDown, linkB.modeDual} = 3'b001;
      {linkB.ch1Data, linkB.ch2Data} = {12'h000, 12'h000};
      repeat (6) @(posedge clk);
      #1 rstn = 1'b1;
      cyc(2);
      check(12'(onB), 12'h001);
      // Dual port: writes alone leave the converters alone
      {linkB.ch1Data, linkB.ch2Data} = {12'hA5A, 12'hFFF};
      cyc(2);
      pulse_b(4'hC);
      check(dac1B, 12'h000);
      check(dac2B, 12'h000);
      pulse_b(4'h2);
      check(dac1B, 12'hA5A);
      check(dac2B, 12'h000);
      pulse_b(4'h1);
      check(dac2B, 12'hFFF);
      // Interleaved with the phase reset held, then released
      linkB.modeDual = 1'b0;
      phaseB = 1'b1;
      linkB.ch2UpdateClock = 1'b1;
      cyc(4);
      load_b(12'h111, 1'b1);
      load_b(12'h222, 1'b0);
      pulse_b(4'h2);
      check(dac1B, 12'hA5A);
      check(dac2B, 12'hFFF);
      phaseB = 1'b0;
      linkB.ch2UpdateClock = 1'b0;
      cyc(4);
      pulse_b(4'h2);
      check(dac1B, 12'h111);
      check(dac2B, 12'h222);
      load_b(12'h333, 1'b1);
      load_b(12'h444, 1'b0);
      pulse_b(4'h2);
      check(dac1B, 12'h111);
      pulse_b(4'h2);
      check(dac1B, 12'h333);
      check(dac2B, 12'h444);
      // Source end, interleaved: each update loads the previous pair
      send(12'h123, 12'h456);
      send(12'h789, 12'hABC);
      check(dac1A, 12'h123);
      check(dac2A, 12'h456);
      send(12'hDEF, 12'h0F0);
      check(dac1A, 12'h789);
      check(dac2A, 12'hABC);
      // Source end, dual port
      userModeDual = 1'b1;
      // Ready still shows the old mode for one edge; let the source drop it first
      cyc(2);
      send(12'h5A5, 12'hA5A);
      send(12'hFFF, 12'h001);
      check(dac1A, 12'h5A5);
      check(dac2A, 12'hA5A);
      send(12'h000, 12'hFFF);
      check(dac1A, 12'hFFF);
      check(dac2A, 12'h001);
      // Sleep entry and recovery on both converter ends
      userPowerDown = 1'b1;
      linkB.powerDown = 1'b1;
      cyc(10);
      check(12'({onA, sleepA, onB, sleepB}), 12'h005);
      userPowerDown = 1'b0;
      linkB.powerDown = 1'b0;
      cyc(6);
      check(12'({onA, sleepA, onB, sleepB}), 12'h000);
      cyc(1010);
      check(12'({onA, sleepA, onB, sleepB}), 12'h00A);
      wrap_up();
   end
endmodule : tb_dual_dac_input_latch_path
